// ---- core/stt_pkg.sv ----
// Package: register map, field positions, reset values and tick constants of timer two
package stt_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0]  STT_CTRL_IDX    = 8'hC8;
	localparam logic [7:0]  STT_MODE_IDX    = 8'hC9;
	localparam logic [7:0]  STT_CNT_LO_IDX  = 8'hCC;
	localparam logic [7:0]  STT_CNT_HI_IDX  = 8'hCD;
	localparam logic [7:0]  STT_RLD_LO_IDX  = 8'hCA;
	localparam logic [7:0]  STT_RLD_HI_IDX  = 8'hCB;
	localparam logic [7:0]  STT_SER_IDX     = 8'hD0;

	// ****************************************
	// Control and mode fields
	// ****************************************
	localparam int          STT_OVF_BIT     = 7;
	localparam int          STT_EXT_BIT     = 6;
	localparam int          STT_RXSRC_BIT   = 5;
	localparam int          STT_TXSRC_BIT   = 4;
	localparam int          STT_TRIGEN_BIT  = 3;
	localparam int          STT_RUN_BIT     = 2;
	localparam int          STT_SRC_BIT     = 1;
	localparam int          STT_CAP_BIT     = 0;
	localparam int          STT_OE_BIT      = 1;
	localparam int          STT_DOWN_COUNT_ENABLE_BIT    = 0;

	// ****************************************
	// Reset values and counts
	// ****************************************
	localparam logic [7:0]  STT_CTRL_RST    = 8'h00;
	localparam logic [1:0]  STT_MODE_RST    = 2'h0;
	localparam logic [15:0] STT_CNT_RST     = 16'h0000;
	localparam logic [15:0] STT_CNT_MAX     = 16'hFFFF;
	localparam int          STT_MACHINE_DIV = 12;
	localparam int          STT_STATE_DIV   = 2;
	localparam logic [1:0]  STT_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  STT_RESP_SLVERR = 2'h2;

	// Byte address of a register index
	function automatic logic [9:0] stt_byte_addr(input logic [7:0] idx);
		stt_byte_addr = {idx, 2'h0};
	endfunction : stt_byte_addr

endpackage : stt_pkg

// ---- core/stt_pin_if.sv ----
// Interface: synchronised pin levels and falling edge strobes
interface stt_pin_if;
	logic trig_level;
	logic trig_fall;
	logic count_fall;
	modport sync (output trig_level, output trig_fall, output count_fall);
	modport core (input trig_level, input trig_fall, input count_fall);
endinterface : stt_pin_if

// ---- core/stt_pin_sync.sv ----
// Synchroniser and falling edge detector for the trigger and count pins
module stt_pin_sync (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Raw pins
	input  wire logic trigger_direction_input,
	input  wire logic external_count_pin,
	// Synchronised result
	stt_pin_if.sync   pins
);
	logic [1:0] trig_sync_reg;
	logic [1:0] cnt_sync_reg;
	logic       trig_prev_reg;
	logic       cnt_prev_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_sync_reg <= 2'h3;
			cnt_sync_reg  <= 2'h3;
			trig_prev_reg <= 1'b1;
			cnt_prev_reg  <= 1'b1;
		end else begin
			trig_sync_reg <= {trig_sync_reg[0], trigger_direction_input};
			cnt_sync_reg  <= {cnt_sync_reg[0], external_count_pin};
			trig_prev_reg <= trig_sync_reg[1];
			cnt_prev_reg  <= cnt_sync_reg[1];
		end
	end

	assign pins.trig_level = trig_sync_reg[1];
	assign pins.trig_fall  = trig_prev_reg & ~trig_sync_reg[1];
	assign pins.count_fall = cnt_prev_reg & ~cnt_sync_reg[1];
endmodule : stt_pin_sync

// ---- core/stt_timer.sv ----
// Sixteen-bit timer two with AXI4-Lite register access
// Overview of operation
// - 16-bit counter; source is internal twelfth-rate tick or external falling edges.
// - Overflow flag set by overflow, cleared by software, never in baud mode.
// - External flag set by trigger capture or reload when enabled; software clears.
// - With down-count enabled the external flag does not request interrupt.
// - Receive-source bit routes this timer's overflow pulses to serial receive.
// - Transmit-source bit routes this timer's overflow pulses to serial transmit.
// - Trigger enable allows trigger falls to capture or reload; clear ignores them.
// - Run bit starts and stops counting; zero means timer off.
// - Capture bit selects capture on trigger; clear selects reload on overflow/trigger.
// - In baud mode capture bit ignored; reload on every overflow.
// - Mode register holds output enable bit 1, down-count enable bit 0.
// - Down-count enable resets to zero, so default counting is upward.
// - Up mode counts to FFFF, then sets overflow flag and reloads.
// - Up mode with trigger enable: trigger fall reloads and sets external flag.
// - Interrupt request when enabled and overflow flag is one, or external flag is one with down-count disabled.
// - Up/down mode, trigger high: count up, overflow sets flag and reloads.
// - Up/down mode, trigger low: count down, match reload value gives underflow.
// - Up/down mode external flag toggles on every overflow and underflow.
// - Baud mode counts at half oscillator rate; serial clocks pulse once per overflow, not overflow/16.
// - Baud mode trigger fall sets external flag without reloading.
module stt_timer
	import stt_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Pins
	input  wire logic        trigger_direction_input,
	input  wire logic        external_count_pin,
	// Serial port and interrupt side
	input  wire logic        timer_one_overflow,
	input  wire logic        timer_irq_enable,
	output logic             serial_rx_clock,
	output logic             serial_tx_clock,
	output logic             timer_irq_req
);

	// ****************************************
	// State
	// ****************************************
	logic [7:0]  ctrl_reg;
	logic [1:0]  mode_reg;
	logic [15:0] count_reg;
	logic [15:0] reload_reg;
	logic [3:0]  presc_reg;
	logic        ovf_pulse_reg;
	logic [3:0]  div16_reg;
	logic        baud_tick_reg;
	logic        clk_out_reg;
	logic        tick;
	logic        baud_mode;
	logic        updown;
	logic        trig_event;
	logic        wrap_up;
	logic        wrap_down;
	logic        ovf_event;
	logic        sw_wr;
	logic [7:0]  sw_wbyte;
	logic [7:0]  sw_widx;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  aw_idx_reg;
	logic [7:0]  w_byte_reg;
	logic        w_lane_reg;

	stt_pin_if pins ();

	stt_pin_sync u_sync (
		.aclk                    (aclk),
		.aresetn                 (aresetn),
		.trigger_direction_input (trigger_direction_input),
		.external_count_pin      (external_count_pin),
		.pins                    (pins)
	);

	// ****************************************
	// Mode decode
	// ****************************************
	// baud mode
	assign baud_mode = ctrl_reg[STT_RXSRC_BIT] | ctrl_reg[STT_TXSRC_BIT];
	assign updown    = mode_reg[STT_DOWN_COUNT_ENABLE_BIT] & ~baud_mode & ~ctrl_reg[STT_CAP_BIT];
	assign trig_event = pins.trig_fall & ctrl_reg[STT_TRIGEN_BIT];

	always_comb begin
		if (ctrl_reg[STT_SRC_BIT])
			tick = pins.count_fall;
		else if (baud_mode)
			tick = (presc_reg == 4'(STT_STATE_DIV - 1)) || (presc_reg == 4'(STT_MACHINE_DIV - 1))
				|| (presc_reg[0] == 1'b1);
		else
			tick = (presc_reg == 4'(STT_MACHINE_DIV - 1));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			presc_reg <= 4'h0;
		else if (presc_reg == 4'(STT_MACHINE_DIV - 1))
			presc_reg <= 4'h0;
		else
			presc_reg <= presc_reg + 4'h1;
	end

	assign wrap_up   = ctrl_reg[STT_RUN_BIT] && tick && (count_reg == STT_CNT_MAX)
		&& !(updown && !pins.trig_level);
	assign wrap_down = ctrl_reg[STT_RUN_BIT] && tick && updown && !pins.trig_level
		&& (count_reg == reload_reg);
	assign ovf_event = wrap_up | wrap_down;

	// ****************************************
	// Counter
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn)
			count_reg <= STT_CNT_RST;
		else if (sw_wr && sw_widx == STT_CNT_LO_IDX)
			count_reg[7:0] <= sw_wbyte;
		else if (sw_wr && sw_widx == STT_CNT_HI_IDX)
			count_reg[15:8] <= sw_wbyte;
		else if (wrap_down)
			count_reg <= STT_CNT_MAX;
		// capture mode rolls over to zero instead
		else if (wrap_up && (baud_mode || !ctrl_reg[STT_CAP_BIT]))
			count_reg <= reload_reg;
		else if (trig_event && !baud_mode && !updown && !ctrl_reg[STT_CAP_BIT])
			count_reg <= reload_reg;
		else if (ctrl_reg[STT_RUN_BIT] && tick && updown && !pins.trig_level)
			count_reg <= count_reg - 16'h0001;
		else if (ctrl_reg[STT_RUN_BIT] && tick)
			count_reg <= count_reg + 16'h0001;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			reload_reg <= STT_CNT_RST;
		else if (trig_event && !baud_mode && ctrl_reg[STT_CAP_BIT])
			reload_reg <= count_reg;
		else if (sw_wr && sw_widx == STT_RLD_LO_IDX)
			reload_reg[7:0] <= sw_wbyte;
		else if (sw_wr && sw_widx == STT_RLD_HI_IDX)
			reload_reg[15:8] <= sw_wbyte;
	end

	// ****************************************
	// Control and mode registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= STT_CTRL_RST;
		end else begin
			if (sw_wr && sw_widx == STT_CTRL_IDX)
				ctrl_reg <= sw_wbyte;
			if (ovf_event && !baud_mode)
				ctrl_reg[STT_OVF_BIT] <= 1'b1;
			if (ovf_event && updown)
				ctrl_reg[STT_EXT_BIT] <= ~ctrl_reg[STT_EXT_BIT];
			else if (trig_event && !updown)
				ctrl_reg[STT_EXT_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mode_reg <= STT_MODE_RST;
		else if (sw_wr && sw_widx == STT_MODE_IDX)
			mode_reg <= sw_wbyte[1:0];
	end

	// ****************************************
	// Serial clocks and interrupt
	// ****************************************
	// Overflow pulse and divide-by-16 baud tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovf_pulse_reg <= 1'b0;
			div16_reg     <= 4'h0;
			baud_tick_reg <= 1'b0;
		end else begin
			ovf_pulse_reg <= ovf_event;
			if (ovf_event)
				div16_reg <= div16_reg + 4'h1;
			baud_tick_reg <= ovf_event && (div16_reg == 4'hF);
		end
	end

	// Clock-out toggle, one edge per overflow
	always_ff @(posedge aclk) begin
		if (!aresetn)
			clk_out_reg <= 1'b0;
		else if (ovf_event && mode_reg[STT_OE_BIT])
			clk_out_reg <= ~clk_out_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_rx_clock <= 1'b0;
			serial_tx_clock <= 1'b0;
		end else begin
			serial_rx_clock <= ctrl_reg[STT_RXSRC_BIT] ? ovf_pulse_reg : timer_one_overflow;
			serial_tx_clock <= ctrl_reg[STT_TXSRC_BIT] ? ovf_pulse_reg : timer_one_overflow;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			timer_irq_req <= 1'b0;
		else
			timer_irq_req <= timer_irq_enable && (ctrl_reg[STT_OVF_BIT]
				|| (ctrl_reg[STT_EXT_BIT] && !mode_reg[STT_DOWN_COUNT_ENABLE_BIT]));
	end

	// ****************************************
	// AXI4-Lite write path
	// ****************************************
	assign sw_wr    = aw_held_reg && w_held_reg && !s_axi_bvalid;
	// Cleared low lane strobe steers the byte to no register
	assign sw_widx  = w_lane_reg ? aw_idx_reg : 8'h00;
	assign sw_wbyte = w_byte_reg;

	// Ready pulses last one cycle so each item is taken exactly once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
		end
	end

	// Address and data halves held until the response is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_idx_reg  <= 8'h00;
			w_byte_reg  <= 8'h00;
			w_lane_reg  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_idx_reg  <= s_axi_awaddr[9:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_byte_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end
			if (s_axi_bvalid && s_axi_bready) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end
		end
	end

	// The write lands on the edge at which the response rises
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= STT_RESP_OKAY;
		end else if (sw_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= is_mapped(aw_idx_reg) ? STT_RESP_OKAY : STT_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx == STT_CTRL_IDX) || (idx == STT_MODE_IDX) || (idx == STT_CNT_LO_IDX)
			|| (idx == STT_CNT_HI_IDX) || (idx == STT_RLD_LO_IDX) || (idx == STT_RLD_HI_IDX)
			|| (idx == STT_SER_IDX);
	endfunction : is_mapped

	// ****************************************
	// AXI4-Lite read path
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= STT_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= is_mapped(s_axi_araddr[9:2]) ? STT_RESP_OKAY : STT_RESP_SLVERR;
				case (s_axi_araddr[9:2])
					STT_CTRL_IDX:   s_axi_rdata <= {24'h0, ctrl_reg};
					STT_MODE_IDX:   s_axi_rdata <= {30'h0, mode_reg};
					STT_CNT_LO_IDX: s_axi_rdata <= {24'h0, count_reg[7:0]};
					STT_CNT_HI_IDX: s_axi_rdata <= {24'h0, count_reg[15:8]};
					STT_RLD_LO_IDX: s_axi_rdata <= {24'h0, reload_reg[7:0]};
					STT_RLD_HI_IDX: s_axi_rdata <= {24'h0, reload_reg[15:8]};
					STT_SER_IDX:    s_axi_rdata <= {29'h0, clk_out_reg, baud_tick_reg, pins.trig_level};
					default:        s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : stt_timer

// ---- verification/stt_timer_chk.sv ----
// Checker: port assertions of timer two
module stt_timer_chk (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Serial and interrupt side
	input wire logic        timer_irq_enable,
	input wire logic        serial_rx_clock,
	input wire logic        serial_tx_clock,
	input wire logic        timer_irq_req
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	irq_needs_en_a: assert property (timer_irq_req |-> $past(timer_irq_enable))
		else $error("interrupt request without enable");
	rx_pulse_a: assert property (serial_rx_clock |=> !serial_rx_clock)
		else $error("receive clock pulse too long");
	tx_pulse_a: assert property (serial_tx_clock |=> !serial_tx_clock)
		else $error("transmit clock pulse too long");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	awready_cause_a: assert property (s_axi_awready |-> s_axi_awvalid)
		else $error("write address taken without valid");
	aw_resp_a: assert property (s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("write response missing");
	ar_answer_a: assert property ($rose(s_axi_arvalid) |-> ##[1:4] s_axi_arready)
		else $error("read address not taken");
	rdata_after_a: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
endmodule : stt_timer_chk

bind stt_timer stt_timer_chk u_stt_timer_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .timer_irq_enable, .serial_rx_clock, .serial_tx_clock, .timer_irq_req);

// ---- verification/stt_far_model.sv ----
// Far side model: trigger and count pins, other timer overflow pulses
module stt_far_model #(
	parameter int OVF_GAP = 10
) (
	// Clock
	input  wire logic aclk,
	// Bench requests
	input  wire logic trig_req,
	input  wire logic cnt_req,
	// Pins and serial source
	output logic      trigger_direction_input,
	output logic      external_count_pin,
	output logic      timer_one_overflow
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] low_cnt = 2'h0;
	int         gap = 0;
	initial begin
		trigger_direction_input = 1'h1;
		external_count_pin = 1'h1;
		timer_one_overflow = 1'h0;
	end
	// Pins idle high, count pin low three cycles per request
	always @(posedge aclk) begin
		trigger_direction_input <= trig_req;
		low_cnt <= cnt_req ? 2'h3 : (low_cnt != 2'h0 ? low_cnt - 2'h1 : 2'h0);
		external_count_pin <= !(cnt_req || low_cnt > 2'h1);
		gap <= (gap == OVF_GAP - 1) ? 0 : gap + 1;
		timer_one_overflow <= (gap == OVF_GAP - 1);
	end
endmodule : stt_far_model

// ---- verification/tb_top.sv ----
// Testbench: register, pin and serial clock checks of timer two
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top
	import stt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1, timer_irq_enable = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        trigger_direction_input, external_count_pin, timer_one_overflow;
	logic        serial_rx_clock, serial_tx_clock, timer_irq_req;
	logic        trig_req = 1'h1, cnt_req = 1'h0;
	logic [15:0] r, c;
	logic [7:0]  d;
	int          mismatches = 0, comparisons = 0, i, t, x;

	stt_timer u_stt_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .trigger_direction_input, .external_count_pin,
		.timer_one_overflow, .timer_irq_enable, .serial_rx_clock, .serial_tx_clock, .timer_irq_req);
	stt_far_model u_stt_far_model (.aclk, .trig_req, .cnt_req, .trigger_direction_input,
		.external_count_pin, .timer_one_overflow);

	always #4 aclk = ~aclk;

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		int n;
		n = 0;
		s_axi_awaddr <= {22'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			test_done();
		end
		rs = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [7:0] idx);
		int n;
		n = 0;
		s_axi_araddr <= {22'h0, idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			test_done();
		end
		d = s_axi_rdata[7:0];
		rs = s_axi_rresp;
	endtask : rd
	task automatic cr(input string nm, input logic [7:0] idx, input logic [7:0] e);
		rd(idx);
		`CHK(nm, e, d)
	endtask : cr
	task automatic w16(input logic [7:0] lo, input logic [15:0] v);
		wr(lo, v[7:0]);
		wr(lo + 8'h1, v[15:8]);
	endtask : w16
	task automatic trig();
		trig_req <= 1'h0;
		cyc(8);
		trig_req <= 1'h1;
		cyc(8);
	endtask : trig
	task automatic win(output int tn, output int rn);
		tn = 0;
		rn = 0;
		repeat (100) begin
			@(posedge aclk);
			tn += serial_tx_clock;
			rn += serial_rx_clock;
		end
	endtask : win

	initial begin
		void'($urandom(14));
		cyc(6);
		aresetn <= 1'h1;
		cr("ctrl", STT_CTRL_IDX, STT_CTRL_RST);
		cr("mode", STT_MODE_IDX, 8'h00);
		rd(8'h00);
		`CHK("resp", STT_RESP_SLVERR, rs)
		wr(8'h00, 8'hFF);
		`CHK("bresp", STT_RESP_SLVERR, rs)
		$display("test reset done");
		w16(STT_CNT_LO_IDX, 16'h0000);
		x = $urandom_range(10, 3);
		wr(STT_CTRL_IDX, 8'h06);
		`CHK("bresp", STT_RESP_OKAY, rs)
		repeat (x) begin
			cnt_req <= 1'h1;
			cyc(1);
			cnt_req <= 1'h0;
			cyc(5);
		end
		cyc(5);
		cr("count lo", STT_CNT_LO_IDX, 8'(x));
		$display("test edge count done");
		r = 16'($urandom);
		w16(STT_RLD_LO_IDX, r);
		wr(STT_CTRL_IDX, 8'h0E);
		trig();
		cr("ctrl", STT_CTRL_IDX, 8'h4E);
		cr("count lo", STT_CNT_LO_IDX, r[7:0]);
		cr("count hi", STT_CNT_HI_IDX, r[15:8]);
		c = 16'($urandom);
		wr(STT_CTRL_IDX, 8'h0F);
		w16(STT_CNT_LO_IDX, c);
		trig();
		cr("ctrl", STT_CTRL_IDX, 8'h4F);
		cr("rld lo", STT_RLD_LO_IDX, c[7:0]);
		cr("rld hi", STT_RLD_HI_IDX, c[15:8]);
		wr(STT_CTRL_IDX, 8'h06);
		w16(STT_CNT_LO_IDX, r);
		trig();
		cr("ctrl", STT_CTRL_IDX, 8'h06);
		cr("count hi", STT_CNT_HI_IDX, r[15:8]);
		$display("test trigger done");
		wr(STT_CTRL_IDX, 8'h00);
		w16(STT_RLD_LO_IDX, 16'hFFF0);
		w16(STT_CNT_LO_IDX, 16'hFFFE);
		timer_irq_enable <= 1'h1;
		wr(STT_CTRL_IDX, 8'h04);
		i = 0;
		do begin
			rd(STT_CTRL_IDX);
			i++;
		end while (d[7] !== 1'h1 && i < 40);
		`CHK("ctrl", 8'h84, d)
		cyc(2);
		`CHK("irq", 1'h1, timer_irq_req)
		wr(STT_CTRL_IDX, 8'h00);
		cyc(2);
		`CHK("irq", 1'h0, timer_irq_req)
		rd(STT_CNT_LO_IDX);
		`CHK("reloaded", 6'h3C, d[7:2])
		x = d;
		cyc(50);
		cr("count lo", STT_CNT_LO_IDX, 8'(x));
		$display("test overflow done");
		r = 16'($urandom) & 16'h7FFF;
		w16(STT_RLD_LO_IDX, r);
		w16(STT_CNT_LO_IDX, r + 16'h1);
		wr(STT_MODE_IDX, 8'h01);
		cr("mode", STT_MODE_IDX, 8'h01);
		trig_req <= 1'h0;
		wr(STT_CTRL_IDX, 8'h04);
		cyc(40);
		cr("ctrl", STT_CTRL_IDX, 8'hC4);
		cr("count hi", STT_CNT_HI_IDX, 8'hFF);
		wr(STT_CTRL_IDX, 8'h40);
		cyc(2);
		`CHK("irq", 1'h0, timer_irq_req)
		wr(STT_MODE_IDX, 8'h00);
		cyc(2);
		`CHK("irq", 1'h1, timer_irq_req)
		trig_req <= 1'h1;
		wr(STT_CTRL_IDX, 8'h00);
		w16(STT_RLD_LO_IDX, 16'h1234);
		w16(STT_CNT_LO_IDX, 16'hFFFF);
		wr(STT_MODE_IDX, 8'h01);
		wr(STT_CTRL_IDX, 8'h04);
		cyc(20);
		cr("ctrl", STT_CTRL_IDX, 8'hC4);
		cr("count hi", STT_CNT_HI_IDX, 8'h12);
		wr(STT_MODE_IDX, 8'h00);
		$display("test up down done");
		wr(STT_CTRL_IDX, 8'h00);
		w16(STT_RLD_LO_IDX, 16'hFFFE);
		w16(STT_CNT_LO_IDX, 16'hFFFE);
		wr(STT_CTRL_IDX, 8'h24);
		win(t, x);
		`CHK("rx rate", 1'h1, x inside {[23:27]})
		`CHK("tx rate", 1'h1, t inside {[9:11]})
		wr(STT_CTRL_IDX, 8'h38);
		w16(STT_CNT_LO_IDX, 16'h1234);
		trig();
		cr("count lo", STT_CNT_LO_IDX, 8'h34);
		wr(STT_CTRL_IDX, 8'h3C);
		trig();
		cr("ctrl", STT_CTRL_IDX, 8'h7C);
		$display("test baud done");
		test_done();
	end
endmodule : tb_top
